/* verilog/clhp_regs.vh */
// clhp_regs.vh: constants for the character display host port
// assumes inclusion by clhp_host_port.v only; definitions only
`ifndef CLHP_REGS_VH
`define CLHP_REGS_VH
// instruction decode
`define CLHP_OP_GLYPH_TOP     2'h1
`define CLHP_OP_SHIFT_TOP     4'h1
// address ranges of the character code ram
`define CLHP_ONE_ROW_LAST     7'h4F
`define CLHP_ROW0_LAST        7'h27
`define CLHP_ROW1_FIRST       7'h40
`define CLHP_ROW1_LAST        7'h67
// strap decode, {hi, lo}
`define CLHP_IF_PARALLEL      2'h0
`define CLHP_IF_TWO_WIRE      2'h1
`define CLHP_IF_FOUR_LINE     2'h2
// two-wire slave address, upper five bits
`define CLHP_SLAVE_ADDR_TOP   5'h0F
// internal operation time, in clock cycles at 40 MHz (18.5 us)
`define CLHP_OP_TIME_NS       18500
`define CLHP_CLK_NS           25
`define CLHP_BUSY_CYCLES      ((`CLHP_OP_TIME_NS + `CLHP_CLK_NS - 1) / `CLHP_CLK_NS)
// reset values
`define CLHP_RST_INC          1'b1
`define CLHP_RST_TWO_ROW      1'b0
`define CLHP_RST_WIDTH8       1'b1
`endif

/* verilog/clhp_host_port.v */
// clhp_host_port.v: host command/data port of a character display controller
// assumes pins arrive asynchronous to clk_sys; links are far slower than 40 MHz
`timescale 1ns/1ps
`include "clhp_regs.vh"

// Summary of operation
// - write instruction 01xxxxxx loads six-bit glyph address, selects glyph ram
// - write instruction 1xxxxxxx loads seven-bit code address, selects code ram
// - one-row mode: code ram addresses run 00H to 4FH contiguously
// - two-row mode: rows at 00H-27H and 40H-67H
// - instruction read returns busy on DB7, counter below; parallel only
// - data write stores byte into ram chosen by last address set
// - counter steps by one after each data write
// - data read returns byte from selected ram then steps counter; parallel only
// - reads come from refilled output latch; first unprimed read is invalid
// - cursor shift reloads the output latch like address set
// - read right after write yields old prefetched content
// - 4-bit mode moves high nibble then low nibble on DB4-DB7
// - 4-bit mode raises busy only after second nibble
// - 8-bit mode moves a byte per strobe on eight lines
// - straps pick parallel, two-wire or four-line serial link
// - four-line: DB5 select, DB7 data in, DB6 clock, cmd_data_sel chooses
// - four-line clock idles high; sample bit on rising edge
// - SDA changes while SCL high are conditions, not data
// - START is SDA fall with SCL high, STOP is SDA rise
// - direction bit one increments counter, zero decrements
// - row-count bit high selects two-row mode
// - two-wire address 01111xx with low bits from DB0/DB1 straps
// - two-wire words are control byte then byte; flag bits pick target
module clhp_host_port (
  // clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  // link pins
  input  wire       strobe_e,
  input  wire       read_not_write,
  input  wire       cmd_data_sel,
  input  wire [7:0] db_in,
  output reg  [7:0] db_out_q,
  output reg  [7:0] db_oe_q,
  // straps
  input  wire       intf_strap_hi,
  input  wire       intf_strap_lo,
  // configuration from the rest of the controller
  input  wire       entry_inc,
  input  wire       two_row,
  input  wire       bus_width_sel,
  input  wire       cursor_shift,
  input  wire       cursor_right,
  // status
  output reg        busy_flag_q,
  output reg  [6:0] addr_counter_q,
  output reg        ram_is_glyph_q
);

  localparam BUSY_CYC = `CLHP_BUSY_CYCLES;

  // storage
  reg [7:0] char_code_ram [0:127];
  reg [7:0] glyph_ram     [0:63];

  // two-flop synchronisers
  reg [12:0] sy1_q;
  reg [12:0] sy2_q;
  reg [12:0] sy3_q;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sy1_q <= 13'h0000;
      sy2_q <= 13'h0000;
      sy3_q <= 13'h0000;
    end else begin
      sy1_q <= {intf_strap_hi, intf_strap_lo, cmd_data_sel, read_not_write, strobe_e, db_in[7:1], db_in[0]};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end
  wire [7:0] db_s  = sy2_q[7:0];
  wire       e_s   = sy2_q[8];
  wire       rw_s  = sy2_q[9];
  wire       rs_s  = sy2_q[10];
  wire [1:0] if_s  = sy2_q[12:11];
  wire [1:0] strap = {sy2_q[12], sy2_q[11]};

  // next address along the entry direction, wrapped into the valid ranges
  function [6:0] step_addr;
    input [6:0] a;
    input       inc;
    input       glyph;
    input       rows2;
    begin
      if (glyph)
        step_addr = {1'b0, inc ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
      else if (!rows2) begin
        if (inc) step_addr = (a >= `CLHP_ONE_ROW_LAST) ? 7'h00 : a + 7'h01;
        else     step_addr = (a == 7'h00) ? `CLHP_ONE_ROW_LAST : a - 7'h01;
      end else begin
        if (inc) step_addr = (a == `CLHP_ROW0_LAST) ? `CLHP_ROW1_FIRST :
                             (a >= `CLHP_ROW1_LAST) ? 7'h00 : a + 7'h01;
        else     step_addr = (a == `CLHP_ROW1_FIRST) ? `CLHP_ROW0_LAST :
                             (a == 7'h00) ? `CLHP_ROW1_LAST : a - 7'h01;
      end
    end
  endfunction
  function [7:0] ram_rd;
    input [6:0] a;
    input       glyph;
    begin
      ram_rd = glyph ? glyph_ram[a[5:0]] : char_code_ram[a];
    end
  endfunction
  wire [6:0] addr_next = step_addr(addr_counter_q, entry_inc, ram_is_glyph_q, two_row);

  // strap mode reloads on every cycle the synchronised pins hold steady (straps are static)
  reg [1:0] mode_q;
  wire      mode_par = (mode_q == `CLHP_IF_PARALLEL);
  wire      unused_if = ^if_s;

  // serial sampling; pins share DB lines per link
  wire sp_cs_n = db_s[5];
  wire sp_clk  = db_s[6];
  wire sp_din  = db_s[7];
  wire sda     = db_s[6];
  wire scl     = db_s[7];
  reg  sda_p_q;
  reg  scl_p_q;
  reg  sclk_p_q;

  // byte delivery strobe from any link
  reg       byt_v;
  reg       byt_rs;
  reg       byt_rd;
  reg [7:0] byt;

  // parallel strobe edge and nibble tracking
  reg       e_p_q;
  reg       nib_lo_q;
  reg [3:0] nib_hi_q;
  // serial shift state
  reg [7:0] sh_q;
  reg [2:0] bit_q;
  // two-wire state
  localparam TW_IDLE = 4'h1;
  localparam TW_ADDR = 4'h2;
  localparam TW_CTRL = 4'h4;
  localparam TW_DATA = 4'h8;
  reg [3:0] tw_q;
  reg       tw_ack_q;
  reg       tw_last_ctrl_q;
  reg       tw_ram_q;
  reg [1:0] sa_q;

  reg [7:0]  out_latch_q;
  reg [9:0]  busy_cnt_q;
  reg [1:0]  pre_q;

  // link receivers and core
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= `CLHP_IF_PARALLEL;
      sa_q <= 2'h0;
      e_p_q <= 1'b0;
      nib_lo_q <= 1'b0;
      nib_hi_q <= 4'h0;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      tw_q <= TW_IDLE;
      tw_ack_q <= 1'b0;
      tw_last_ctrl_q <= 1'b0;
      tw_ram_q <= 1'b0;
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
      sclk_p_q <= 1'b1;
      byt_v <= 1'b0;
      byt_rs <= 1'b0;
      byt_rd <= 1'b0;
      byt <= 8'h00;
      db_out_q <= 8'h00;
      db_oe_q <= 8'h00;
      busy_flag_q <= 1'b0;
      busy_cnt_q <= 10'h000;
      addr_counter_q <= 7'h00;
      ram_is_glyph_q <= 1'b0;
      out_latch_q <= 8'h00;
      pre_q <= 2'h0;
    end else begin
      byt_v <= 1'b0;
      e_p_q <= e_s;
      sda_p_q <= sda;
      scl_p_q <= scl;
      sclk_p_q <= sp_clk;
      if (sy3_q == sy2_q) begin
        mode_q <= strap;
        sa_q <= db_s[1:0];
      end
      // parallel bus
      if (mode_par) begin
        if (e_s && !e_p_q && rw_s) begin
          if (!bus_width_sel && nib_lo_q)
            db_out_q <= {rs_s ? out_latch_q[3:0] : addr_counter_q[3:0], 4'h0};
          else if (rs_s)
            db_out_q <= out_latch_q;
          else
            db_out_q <= {busy_flag_q, addr_counter_q};
          db_oe_q <= bus_width_sel ? 8'hFF : 8'hF0;
        end
        if (!e_s && e_p_q) begin
          db_oe_q <= 8'h00;
          if (bus_width_sel) begin
            byt_v <= 1'b1;
            byt <= db_s;
            byt_rs <= rs_s;
            byt_rd <= rw_s;
          end else if (!nib_lo_q) begin
            nib_lo_q <= 1'b1;
            nib_hi_q <= db_s[7:4];
          end else begin
            nib_lo_q <= 1'b0;
            byt_v <= 1'b1;
            byt <= {nib_hi_q, db_s[7:4]};
            byt_rs <= rs_s;
            byt_rd <= rw_s;
          end
        end
      end
      // four-line serial
      if (mode_q == `CLHP_IF_FOUR_LINE) begin
        if (sp_cs_n) begin
          bit_q <= 3'h0;
        end else if (sp_clk && !sclk_p_q) begin
          sh_q <= {sh_q[6:0], sp_din};
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            byt_v <= 1'b1;
            byt <= {sh_q[6:0], sp_din};
            byt_rs <= rs_s;
            byt_rd <= 1'b0;
          end
        end
      end
      // two-wire serial
      if (mode_q == `CLHP_IF_TWO_WIRE) begin
        if (scl && scl_p_q && !sda && sda_p_q) begin
          tw_q <= TW_ADDR;
          bit_q <= 3'h0;
          tw_ack_q <= 1'b1;                         // first scl fall after start is not a byte end
          tw_last_ctrl_q <= 1'b0;
        end else if (scl && scl_p_q && sda && !sda_p_q) begin
          tw_q <= TW_IDLE;
          db_oe_q <= 8'h00;
        end else if (scl && !scl_p_q && !tw_ack_q && tw_q != TW_IDLE) begin
          sh_q <= {sh_q[6:0], sda};
          bit_q <= bit_q + 3'h1;
        end else if (!scl && scl_p_q && tw_q != TW_IDLE) begin
          db_oe_q <= 8'h00;
          if (tw_ack_q) begin
            tw_ack_q <= 1'b0;
          end else if (bit_q == 3'h0) begin
            tw_ack_q <= 1'b1;
            db_out_q <= 8'h00;
            case (tw_q)
              TW_ADDR: begin
                if (sh_q[7:1] == {`CLHP_SLAVE_ADDR_TOP, sa_q} && !sh_q[0]) begin
                  tw_q <= TW_CTRL;
                  db_oe_q <= 8'h40;
                end else begin
                  tw_q <= TW_IDLE;
                  tw_ack_q <= 1'b0;
                end
              end
              TW_CTRL: begin
                tw_q <= TW_DATA;
                tw_last_ctrl_q <= !sh_q[7];
                tw_ram_q <= sh_q[6];
                db_oe_q <= 8'h40;
              end
              TW_DATA: begin
                tw_q <= tw_last_ctrl_q ? TW_DATA : TW_CTRL;
                byt_v <= 1'b1;
                byt <= sh_q;
                byt_rs <= tw_ram_q;
                byt_rd <= 1'b0;
                db_oe_q <= 8'h40;
              end
              default: tw_q <= TW_IDLE;
            endcase
          end
        end
      end
      // busy timing
      if (busy_cnt_q != 10'h000)
        busy_cnt_q <= busy_cnt_q - 10'h001;
      else
        busy_flag_q <= 1'b0;
      // prefetch of the output latch after address set, cursor shift and data read
      if (pre_q != 2'h0) begin
        pre_q <= pre_q - 2'h1;
        if (pre_q == 2'h1)
          out_latch_q <= ram_rd(addr_counter_q, ram_is_glyph_q);
      end
      if (cursor_shift && !ram_is_glyph_q) begin
        addr_counter_q <= step_addr(addr_counter_q, cursor_right, 1'b0, two_row);
        pre_q <= 2'h2;
      end
      // execute a delivered byte
      if (byt_v) begin
        if (!byt_rs && !byt_rd) begin
          if (byt[7]) begin
            addr_counter_q <= byt[6:0];
            ram_is_glyph_q <= 1'b0;
            pre_q <= 2'h2;
          end else if (byt[7:6] == `CLHP_OP_GLYPH_TOP) begin
            addr_counter_q <= {1'b0, byt[5:0]};
            ram_is_glyph_q <= 1'b1;
            pre_q <= 2'h2;
          end
          busy_flag_q <= 1'b1;
          busy_cnt_q <= BUSY_CYC[9:0];
        end else if (byt_rs && !byt_rd) begin
          if (ram_is_glyph_q)
            glyph_ram[addr_counter_q[5:0]] <= byt;
          else
            char_code_ram[addr_counter_q] <= byt;
          addr_counter_q <= addr_next;
          busy_flag_q <= 1'b1;
          busy_cnt_q <= BUSY_CYC[9:0];
        end else if (byt_rs && byt_rd) begin
          addr_counter_q <= addr_next;
          pre_q <= 2'h2;
        end
      end
    end
  end

endmodule

/* tb/clhp_host_port_props.sv */
// clhp_host_port_props.sv: checker for the 8-bit parallel side of the host port
// assumes it is bound to clhp_host_port and sees only its ports
`timescale 1ns/1ps
module clhp_host_port_props (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // pins and straps
  input wire logic       strobe_e,
  input wire logic       read_not_write,
  input wire logic       cmd_data_sel,
  input wire logic [7:0] db_in,
  input wire logic [7:0] db_out_q,
  input wire logic [7:0] db_oe_q,
  input wire logic       intf_strap_hi,
  input wire logic       intf_strap_lo,
  // configuration and status
  input wire logic       entry_inc,
  input wire logic       bus_width_sel,
  input wire logic       busy_flag_q,
  input wire logic [6:0] addr_counter_q,
  input wire logic       ram_is_glyph_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic       e_q;
  logic [6:0] ac_q;
  logic [7:0] d_q;
  logic       par8, wr8, ins;
  // strobe edge finder; counter and byte snapshot at each fall
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      e_q <= 1'b0;
      ac_q <= 7'h00;
      d_q <= 8'h00;
    end else begin
      e_q <= strobe_e;
      if (e_q && !strobe_e) begin
        ac_q <= addr_counter_q;
        d_q <= db_in;
      end
    end
  end
  // idle 8-bit parallel write taken at the strobe fall
  assign par8 = bus_width_sel && !intf_strap_hi && !intf_strap_lo;
  assign wr8  = e_q && !strobe_e && !read_not_write && par8 && !busy_flag_q;
  assign ins  = wr8 && !cmd_data_sel;
  a_glyph_set: assert property (
    ins && db_in[7:6] == 2'h1 |-> ##[2:8] ram_is_glyph_q && addr_counter_q == {1'b0, d_q[5:0]})
    else $error("glyph address set not applied");
  a_code_set: assert property (
    ins && db_in[7] |-> ##[2:8] !ram_is_glyph_q && addr_counter_q == d_q[6:0])
    else $error("code address set not applied");
  a_busy_rise: assert property (
    wr8 |-> ##[1:8] busy_flag_q)
    else $error("busy did not rise after a byte write");
  a_step_up: assert property (
    wr8 && cmd_data_sel && entry_inc && !(addr_counter_q inside {7'h27, 7'h3F, 7'h4F, 7'h67, 7'h7F})
    |-> ##[2:8] addr_counter_q == ac_q + 7'h01)
    else $error("counter did not step up after data write");
  a_step_down: assert property (
    wr8 && cmd_data_sel && !entry_inc && !(addr_counter_q inside {7'h00, 7'h40})
    |-> ##[2:8] addr_counter_q == ac_q - 7'h01)
    else $error("counter did not step down after data write");
  a_ram_kept: assert property (
    wr8 && cmd_data_sel |=> $stable(ram_is_glyph_q) [*8])
    else $error("data write changed the ram selection");
  a_read_drive: assert property (
    $rose(strobe_e) && read_not_write && par8 |-> ##[1:8] db_oe_q == 8'hFF)
    else $error("read did not drive the data lines");
  a_status_read: assert property (
    $rose(strobe_e) && read_not_write && !cmd_data_sel && par8 && !busy_flag_q
    |-> ##[4:8] db_out_q == {1'b0, addr_counter_q})
    else $error("status read did not show busy and counter");
endmodule

/* tb/clhp_host_model.sv */
// clhp_host_model.sv: microprocessor on the parallel bus of the host port
// assumes 40 MHz clk_sys; pins change only by non-blocking assignment after its rising edge
`timescale 1ns/1ps
module clhp_host_model (
  // clock and width, nib high for the 4-bit bus
  input  wire logic       clk_sys,
  input  wire logic       nib,
  // device drive
  input  wire logic [7:0] db_out_q,
  input  wire logic [7:0] db_oe_q,
  // host drive
  output logic            strobe_e = 1'b0,
  output logic            read_not_write = 1'b0,
  output logic            cmd_data_sel = 1'b0,
  output logic [7:0]      db_in,
  // ram read results
  output logic            rd_valid = 1'b0,
  output logic [7:0]      rd_data = 8'h00
);
  logic [7:0] drv_q = 8'h00;
  // wire level: device where enabled, else host value (inverted once released)
  always_comb for (int i = 0; i < 8; i++) db_in[i] = db_oe_q[i] ? db_out_q[i] : drv_q[i];
  // one strobe: 10 cycles high, byte taken at the fall, 10 cycles of hold and recovery
  task automatic cyc(input logic rnw, input logic rs, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_sys);
    read_not_write <= rnw;
    cmd_data_sel <= rs;
    if (!rnw) drv_q <= d;
    @(posedge clk_sys);
    strobe_e <= 1'b1;
    repeat (10) @(posedge clk_sys);
    r = db_in;
    strobe_e <= 1'b0;
    repeat (10) @(posedge clk_sys);
    drv_q <= ~drv_q;
  endtask
  // one byte, split into nibbles on the upper lines when nib is set
  task automatic xfer(input logic rnw, input logic rs, input logic [7:0] d, output logic [7:0] r);
    logic [7:0] a, b;
    if (nib) begin
      cyc(rnw, rs, {d[7:4], 4'h0}, a);
      cyc(rnw, rs, {d[3:0], 4'h0}, b);
      r = {a[7:4], b[7:4]};
    end else cyc(rnw, rs, d, r);
    if (rnw && rs) begin
      rd_data <= r;
      rd_valid <= 1'b1;
      @(posedge clk_sys);
      rd_valid <= 1'b0;
    end
  endtask
  // poll status until busy reads low, then leave a margin
  task automatic wait_ready(output logic [7:0] s, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      xfer(1'b1, 1'b0, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
    repeat (20) @(posedge clk_sys);
  endtask
endmodule

/* tb/tb.sv */
// tb.sv: top bench for the host port on the 8-bit and 4-bit parallel bus
// assumes clhp_host_model as the microprocessor; checker bound at the foot
`timescale 1ns/1ps
module tb;
  // clock, reset and core-side levels
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       entry_inc = 1'b1;
  logic       two_row = 1'b0;
  logic       bus_width_sel = 1'b1;
  logic       cursor_shift = 1'b0;
  logic       cursor_right = 1'b0;
  wire        strobe_e, read_not_write, cmd_data_sel, rd_valid, busy_flag_q, ram_is_glyph_q;
  wire  [7:0] db_in, db_out_q, db_oe_q, rd_data;
  wire  [6:0] addr_counter_q;
  int         failures = 0;
  int         compares = 0;
  logic [7:0] exp_q[$];
  logic [7:0] s, r, d1, d2;
  logic       ok;
  always #12.5 clk_sys = ~clk_sys;
  clhp_host_port u_dut (.clk_sys, .sys_rst, .strobe_e, .read_not_write, .cmd_data_sel, .db_in, .db_out_q,
    .db_oe_q, .intf_strap_hi(1'b0), .intf_strap_lo(1'b0), .entry_inc, .two_row, .bus_width_sel, .cursor_shift,
    .cursor_right, .busy_flag_q, .addr_counter_q, .ram_is_glyph_q);
  clhp_host_model u_host (.clk_sys, .nib(!bus_width_sel), .db_out_q, .db_oe_q, .strobe_e, .read_not_write,
    .cmd_data_sel, .db_in, .rd_valid, .rd_data);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // write one byte, then poll until the device is free
  task automatic op(input logic rs, input logic [7:0] d);
    u_host.xfer(1'b0, rs, d, r);
    u_host.wait_ready(s, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
  endtask
  // read one ram byte after noting what it should hold
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b1, 1'b1, 8'h00, r);
  endtask
  // oldest note against each ram read result
  always @(posedge clk_sys) if (rd_valid === 1'b1) chk("ram read", exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data, rd_data);
  initial begin
    void'($urandom(1));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("status after reset", 8'h00, {busy_flag_q, addr_counter_q});
    $display("reset test done");
    op(1'b0, 8'hC5);
    chk("code address", 8'h45, {ram_is_glyph_q, addr_counter_q});
    chk("status read", 8'h45, s);
    op(1'b1, d1);
    op(1'b1, d2);
    chk("counter after writes", 8'h47, {ram_is_glyph_q, addr_counter_q});
    op(1'b0, 8'hC5);
    rd(d1);
    rd(d2);
    chk("counter after reads", 8'h47, {ram_is_glyph_q, addr_counter_q});
    cursor_shift <= 1'b1;
    @(posedge clk_sys);
    cursor_shift <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("counter after shift", 8'h46, {ram_is_glyph_q, addr_counter_q});
    rd(d2);
    $display("code ram test done");
    entry_inc <= 1'b0;
    op(1'b0, 8'h7F);
    chk("glyph address", 8'hBF, {ram_is_glyph_q, addr_counter_q});
    op(1'b1, d1);
    chk("glyph step down", 8'hBE, {ram_is_glyph_q, addr_counter_q});
    entry_inc <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      two_row <= i[0];
      op(1'b0, 8'hA7);
      op(1'b1, d2);
      chk("row end step", (i == 1) ? 8'h40 : 8'h28, {ram_is_glyph_q, addr_counter_q});
    end
    $display("glyph and row test done");
    bus_width_sel <= 1'b0;
    @(posedge clk_sys);
    u_host.cyc(1'b0, 1'b0, 8'h80, r);
    chk("busy after first nibble", 8'h00, {7'h00, busy_flag_q});
    u_host.cyc(1'b0, 1'b0, 8'h50, r);
    chk("busy after second nibble", 8'h01, {7'h00, busy_flag_q});
    u_host.wait_ready(s, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
    chk("nibble address", 8'h05, {ram_is_glyph_q, addr_counter_q});
    op(1'b1, d1);
    op(1'b0, 8'h85);
    rd(d1);
    repeat (4) @(posedge clk_sys);
    $display("nibble test done");
    summarize();
  end
endmodule
bind clhp_host_port clhp_host_port_props u_props (.clk_sys, .sys_rst, .strobe_e, .read_not_write, .cmd_data_sel,
  .db_in, .db_out_q, .db_oe_q, .intf_strap_hi, .intf_strap_lo, .entry_inc, .bus_width_sel, .busy_flag_q,
  .addr_counter_q, .ram_is_glyph_q);
